/* rtl/lws_supervisor.sv */
`timescale 1ns/1ps
module lws_supervisor
    import lws_pkg::*;
#(
    parameter logic [3:0] LVR_LEVEL = LWS_LVL_DEFAULT  // Build-time threshold code
)
(
    input  wire logic       core_clk_i,        // 40 MHz clock
    input  wire logic       reset_n_i,         // Sync reset, active low
    input  wire logic       osc_tick_i,        // Slow oscillator level, from pin
    input  wire logic       osc_en_i,          // Slow oscillator enabled
    input  wire logic       por_done_i,        // Power-on sequence complete, from pin
    input  wire logic       vdd_low_i,         // Comparator: supply below threshold, pin
    input  wire logic       lvr_dis_i,         // Low-voltage reset software disable
    input  wire logic       stop_exe_i,        // Halt-execution stop mode
    input  wire logic       stop_sys_i,        // Full system stop mode
    input  wire logic       wdt_en_set_i,      // Pulse: software enables watchdog
    input  wire logic       calib_run_i,       // Pulse: calibration routine closes watchdog
    input  wire logic       wdt_clr_i,         // Pulse: software clears watchdog
    input  wire logic [1:0] wdt_per_i,         // Watchdog period select
    input  wire logic       fast_wake_i,       // Fast wakeup selected
    input  wire logic       pwr_down_i,        // Pulse: enter power-down
    input  wire logic       wake_i,            // Wake event, from pin
    output logic [3:0]      lvr_level_o,       // Threshold code applied to comparator
    output logic            lvr_active_o,      // Low-voltage reset armed
    output logic            wdt_en_o,          // Watchdog enabled
    output logic            cpu_run_o,         // Execution permitted
    output logic            sys_rst_o          // System reset request
);
    logic osc_s, por_s, low_s, wake_s;
    logic osc_prev_q, osc_prev_d;
    logic tick;

    lws_sync u_osc  (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .async_i(osc_tick_i),
                     .sync_o(osc_s));
    lws_sync u_por  (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .async_i(por_done_i),
                     .sync_o(por_s));
    lws_sync u_low  (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .async_i(vdd_low_i),
                     .sync_o(low_s));
    lws_sync u_wake (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .async_i(wake_i),
                     .sync_o(wake_s));

    // One tick per slow-oscillator period; none when oscillator is off
    assign tick = osc_s & ~osc_prev_q & osc_en_i;  // see RULE6

    logic [18:0] wdt_cnt_q, wdt_cnt_d;
    logic        wdt_en_q, wdt_en_d;
    logic        lvr_act_q, lvr_act_d;
    logic [3:0]  lvl_q, lvl_d;
    logic        por_seen_q, por_seen_d;
    logic        wdt_fire;
    logic        lvr_fire;
    logic [2:0]  rst_cnt_q, rst_cnt_d;
    logic        rst_q, rst_d;
    lws_pwr_e    st_q, st_d;
    logic [5:0]  wk_cnt_q, wk_cnt_d;
    logic        run_q, run_d;

    assign wdt_fire = wdt_en_q & tick & (wdt_cnt_q + 19'h00001 >= lws_period(wdt_per_i));
    assign lvr_fire = lvr_act_q & low_s;

    always_comb
    begin
        osc_prev_d = osc_s;
        por_seen_d = por_seen_q | por_s;
        // Threshold latched once power-on completes
        lvl_d      = (por_s & ~por_seen_q) ? LVR_LEVEL : lvl_q;  // see RULE3
        lvr_act_d  = por_seen_q & ~lvr_dis_i & ~stop_exe_i & ~stop_sys_i;  // see RULE1 RULE2
        wdt_en_d   = wdt_en_q;
        if (calib_run_i)
            wdt_en_d = 1'b0;  // see RULE7
        if (wdt_en_set_i)
            wdt_en_d = 1'b1;  // see RULE7
        wdt_cnt_d  = wdt_cnt_q;
        if (wdt_clr_i || !wdt_en_q || wdt_fire)
            wdt_cnt_d = 19'h00000;
        else if (tick)
            wdt_cnt_d = wdt_cnt_q + 19'h00001;  // see RULE4 RULE6
        rst_cnt_d  = rst_cnt_q;
        rst_d      = rst_q;
        if (wdt_fire || lvr_fire)
        begin
            rst_cnt_d = LWS_RST_PULSE;  // see RULE8
            rst_d     = 1'b1;
        end
        else if (rst_cnt_q != 3'h0)
            rst_cnt_d = rst_cnt_q - 3'h1;
        else
            rst_d = 1'b0;
    end

    always_comb
    begin
        st_d     = st_q;
        wk_cnt_d = wk_cnt_q;
        run_d    = run_q;
        case (st_q)
            LWS_RUN:
            begin
                run_d = 1'b1;
                if (pwr_down_i)
                begin
                    st_d  = LWS_DOWN;
                    run_d = 1'b0;
                end
            end
            LWS_DOWN:
            begin
                if (wake_s)
                begin
                    wk_cnt_d = 6'h00;
                    if (fast_wake_i)
                        st_d = LWS_WAKE;
                    else
                    begin
                        st_d  = LWS_RUN;
                        run_d = 1'b1;
                    end
                end
            end
            LWS_WAKE:
            begin
                if (tick)
                begin
                    wk_cnt_d = wk_cnt_q + 6'h01;
                    if (wk_cnt_q + 6'h01 == LWS_FAST_WAKE)
                    begin
                        st_d  = LWS_RUN;  // see RULE5
                        run_d = 1'b1;
                    end
                end
            end
            default:
            begin
                st_d  = LWS_RUN;
                run_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            osc_prev_q <= 1'b0;
            por_seen_q <= 1'b0;
            lvl_q      <= LWS_LVL_DEFAULT;
            lvr_act_q  <= 1'b0;
            wdt_en_q   <= 1'b1;
            wdt_cnt_q  <= 19'h00000;
            rst_cnt_q  <= 3'h0;
            rst_q      <= 1'b0;
            st_q       <= LWS_RUN;
            wk_cnt_q   <= 6'h00;
            run_q      <= 1'b1;
        end
        else
        begin
            osc_prev_q <= osc_prev_d;
            por_seen_q <= por_seen_d;
            lvl_q      <= lvl_d;
            lvr_act_q  <= lvr_act_d;
            wdt_en_q   <= wdt_en_d;
            wdt_cnt_q  <= wdt_cnt_d;
            rst_cnt_q  <= rst_cnt_d;
            rst_q      <= rst_d;
            st_q       <= st_d;
            wk_cnt_q   <= wk_cnt_d;
            run_q      <= run_d;
        end
    end

    always_comb
    begin
        lvr_level_o  = lvl_q;
        lvr_active_o = lvr_act_q;
        wdt_en_o     = wdt_en_q;
        cpu_run_o    = run_q;
        sys_rst_o    = rst_q;
    end

    chk_lvr_disable_off: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        lvr_dis_i |=> !lvr_active_o) else $error("lvr active while disabled");  // see RULE1
    chk_lvr_stop_off: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (stop_exe_i || stop_sys_i) |=> !lvr_active_o) else $error("lvr active in stop");  // see RULE2
    chk_lvr_needs_por: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !por_seen_q |=> !lvr_active_o) else $error("lvr active before power-on");  // see RULE3
    chk_level_latch: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (por_s && !por_seen_q) |=> lvr_level_o == LVR_LEVEL) else $error("level not applied");  // see RULE3
    chk_wdt_period: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $changed(wdt_cnt_q) |-> wdt_cnt_q < lws_period($past(wdt_per_i)))
        else $error("watchdog count past period");  // see RULE4
    chk_wake_count: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (st_q == LWS_WAKE) |-> wk_cnt_q < LWS_FAST_WAKE) else $error("wake count overrun");  // see RULE5
    chk_osc_stop: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (!osc_en_i && !wdt_clr_i && wdt_en_q) |=> $stable(wdt_cnt_q))
        else $error("watchdog ran without oscillator");  // see RULE6
    chk_calib_close: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (calib_run_i && !wdt_en_set_i) |=> !wdt_en_o) else $error("watchdog not closed");  // see RULE7
    chk_wdt_reset: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        wdt_fire |=> sys_rst_o [*4]) else $error("watchdog reset missing");  // see RULE8
endmodule : lws_supervisor

/* rtl/lws_pkg.sv */
// Overview of operation
// RULE1: Low-voltage reset is disabled while its software disable bit is one.
// RULE2: Low-voltage reset stays inactive in halt-execution or full-system stop modes.
// RULE3: Build-time threshold applies only after power-on sequence completes successfully.
// RULE4: Period field selects 8192, 16384, 65536 or 262144 slow-oscillator periods.
// RULE5: Fast wakeup resumes execution 45 slow-oscillator periods after a wake event.
// RULE6: Watchdog counter stops whenever the slow internal oscillator is disabled.
// RULE7: Watchdog enabled after reset; calibration routine closes it until re-enabled.
// RULE8: Enabled watchdog reaching timeout without a clear issues a system reset.
package lws_pkg;
    localparam int          LWS_WDT_W        = 19;
    localparam logic [18:0] LWS_WDT_P0       = 19'h02000;
    localparam logic [18:0] LWS_WDT_P1       = 19'h04000;
    localparam logic [18:0] LWS_WDT_P2       = 19'h10000;
    localparam logic [18:0] LWS_WDT_P3       = 19'h40000;
    localparam logic [5:0]  LWS_FAST_WAKE    = 6'h2D;
    localparam logic [3:0]  LWS_LVL_DEFAULT  = 4'h0;
    localparam logic [1:0]  LWS_PER_DEFAULT  = 2'h0;
    localparam logic [2:0]  LWS_RST_PULSE    = 3'h4;

    typedef enum logic [2:0] {
        LWS_RUN  = 3'b001,
        LWS_DOWN = 3'b010,
        LWS_WAKE = 3'b100
    } lws_pwr_e;

    function automatic logic [18:0] lws_period(input logic [1:0] sel);
        case (sel)
            2'h0:    lws_period = LWS_WDT_P0;
            2'h1:    lws_period = LWS_WDT_P1;
            2'h2:    lws_period = LWS_WDT_P2;
            default: lws_period = LWS_WDT_P3;
        endcase
    endfunction : lws_period
endpackage : lws_pkg

/* rtl/lws_sync.sv */
`timescale 1ns/1ps
module lws_sync
(
    input  wire logic core_clk_i,  // Clock
    input  wire logic reset_n_i,   // Sync reset, active low
    input  wire logic async_i,     // Asynchronous level
    output logic      sync_o       // Synchronised level
);
    logic meta_q;
    logic meta_d;
    logic sync_d;

    always_comb
    begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            meta_q <= 1'b0;
            sync_o <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_o <= sync_d;
        end
    end
endmodule : lws_sync

/* dv/lws_supervisor_tb.sv */
`timescale 1ns/1ps
module testbench;
    import lws_pkg::*;
    localparam logic [3:0] LEVEL = 4'h9;

    logic       core_clk_i   = 1'b0;
    logic       reset_n_i    = 1'b0;
    logic       osc_tick_i   = 1'b0;
    logic       osc_en_i     = 1'b0;
    logic       por_done_i   = 1'b0;
    logic       vdd_low_i    = 1'b0;
    logic       lvr_dis_i    = 1'b0;
    logic       stop_exe_i   = 1'b0;
    logic       stop_sys_i   = 1'b0;
    logic       wdt_en_set_i = 1'b0;
    logic       calib_run_i  = 1'b0;
    logic       wdt_clr_i    = 1'b0;
    logic [1:0] wdt_per_i    = 2'h0;
    logic       fast_wake_i  = 1'b0;
    logic       pwr_down_i   = 1'b0;
    logic       wake_i       = 1'b0;
    logic [3:0] lvr_level_o;
    logic       lvr_active_o;
    logic       wdt_en_o;
    logic       cpu_run_o;
    logic       sys_rst_o;
    logic       rst_seen     = 1'b0;
    int         mismatches   = 0;
    int         checked      = 0;

    lws_supervisor #(.LVR_LEVEL(LEVEL)) i_lws_supervisor (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .osc_tick_i(osc_tick_i),
        .osc_en_i(osc_en_i), .por_done_i(por_done_i), .vdd_low_i(vdd_low_i),
        .lvr_dis_i(lvr_dis_i), .stop_exe_i(stop_exe_i), .stop_sys_i(stop_sys_i),
        .wdt_en_set_i(wdt_en_set_i), .calib_run_i(calib_run_i), .wdt_clr_i(wdt_clr_i),
        .wdt_per_i(wdt_per_i), .fast_wake_i(fast_wake_i), .pwr_down_i(pwr_down_i),
        .wake_i(wake_i), .lvr_level_o(lvr_level_o), .lvr_active_o(lvr_active_o),
        .wdt_en_o(wdt_en_o), .cpu_run_o(cpu_run_o), .sys_rst_o(sys_rst_o));

    always #12.5 core_clk_i = ~core_clk_i;

    // Latch any reset request so short pulses are never missed
    always @(posedge core_clk_i)
        if (sys_rst_o === 1'b1) rst_seen <= 1'b1;

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : cyc

    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse

    // One slow-oscillator period is four core cycles, keeping long timeouts affordable
    task automatic tick(input int n);
        repeat (n)
        begin
            osc_tick_i = 1'b1;
            cyc(2);
            osc_tick_i = 1'b0;
            cyc(2);
        end
    endtask : tick

    task automatic test_reset;
        chk(lvr_level_o, 4'h0, "level before power-on");
        chk({3'h0, lvr_active_o}, 4'h0, "lvr armed before power-on");
        chk({3'h0, wdt_en_o}, 4'h1, "watchdog after reset");
        chk({cpu_run_o, sys_rst_o, 2'h0}, 4'h8, "run and reset request");
    endtask : test_reset

    task automatic test_lvr;
        por_done_i = 1'b1;
        cyc(4);
        chk(lvr_level_o, LEVEL, "level after power-on");
        chk({3'h0, lvr_active_o}, 4'h1, "lvr armed");
        lvr_dis_i = 1'b1;
        cyc(2);
        chk({3'h0, lvr_active_o}, 4'h0, "lvr disabled");
        rst_seen = 1'b0;
        vdd_low_i = 1'b1;
        cyc(6);
        chk({3'h0, rst_seen}, 4'h0, "disabled lvr fired");
        lvr_dis_i = 1'b0;
        cyc(6);
        chk({3'h0, rst_seen}, 4'h1, "low supply reset");
        vdd_low_i = 1'b0;
        stop_exe_i = 1'b1;
        cyc(2);
        chk({3'h0, lvr_active_o}, 4'h0, "lvr in halt stop");
        stop_exe_i = 1'b0;
        stop_sys_i = 1'b1;
        cyc(2);
        chk({3'h0, lvr_active_o}, 4'h0, "lvr in system stop");
        stop_sys_i = 1'b0;
        cyc(10);
        chk({3'h0, lvr_active_o}, 4'h1, "lvr rearmed");
    endtask : test_lvr

    task automatic test_enable;
        pulse(calib_run_i);
        cyc(1);
        chk({3'h0, wdt_en_o}, 4'h0, "calibration closes watchdog");
        pulse(wdt_en_set_i);
        cyc(1);
        chk({3'h0, wdt_en_o}, 4'h1, "watchdog reopened");
    endtask : test_enable

    task automatic test_watchdog;
        wdt_per_i = 2'h0;
        osc_en_i = 1'b1;
        pulse(wdt_clr_i);
        rst_seen = 1'b0;
        tick(8000);
        osc_en_i = 1'b0;
        tick(300);
        osc_en_i = 1'b1;
        tick(191);
        cyc(8);
        chk({3'h0, rst_seen}, 4'h0, "early timeout");
        chk({3'h0, rst_seen}, 4'h0, "counted while osc off");
        tick(1);
        cyc(2);
        chk({3'h0, rst_seen}, 4'h1, "timeout at 8192 ticks");
    endtask : test_watchdog

    task automatic test_period;
        // Let the previous reset pulse die out before watching again
        cyc(8);
        pulse(wdt_clr_i);
        wdt_per_i = 2'h1;
        rst_seen = 1'b0;
        tick(8192);
        cyc(2);
        chk({3'h0, rst_seen}, 4'h0, "period 01 expired at 8192 ticks");
        pulse(wdt_clr_i);
        wdt_per_i = 2'h0;
        tick(1);
        cyc(2);
        chk({3'h0, rst_seen}, 4'h0, "cleared watchdog fired");
    endtask : test_period

    task automatic test_wake;
        pulse(calib_run_i);
        pulse(pwr_down_i);
        cyc(1);
        chk({3'h0, cpu_run_o}, 4'h0, "power-down halts");
        wake_i = 1'b1;
        cyc(5);
        chk({3'h0, cpu_run_o}, 4'h1, "normal wake");
        wake_i = 1'b0;
        // Wait for the synchronised wake level to drop before sleeping again
        cyc(3);
        fast_wake_i = 1'b1;
        pulse(pwr_down_i);
        wake_i = 1'b1;
        cyc(4);
        wake_i = 1'b0;
        tick(44);
        chk({3'h0, cpu_run_o}, 4'h0, "fast wake too early");
        tick(1);
        chk({3'h0, cpu_run_o}, 4'h1, "fast wake after 45 ticks");
    endtask : test_wake

    task automatic test_done;
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    initial
    begin
        #(90000 * 25);
        mismatches++;
        $display("Error %0t: timeout", $time);
        test_done();
    end

    initial
    begin
        cyc(4);
        reset_n_i = 1'b1;
        cyc(1);
        test_reset();
        test_lvr();
        test_enable();
        test_watchdog();
        test_period();
        test_wake();
        test_done();
    end
endmodule : testbench
